/* hdl/uvs_pkg.sv */
// constants and types shared by the volume stepper design
package uvs_pkg;
    // system clock rate
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    // internal step clock, nominal rate
    localparam int unsigned INT_CLK_HZ = 100;
    // divider count for one internal step-clock enable
    localparam int unsigned INT_DIV_CYC = SYS_CLK_HZ / INT_CLK_HZ;
    // step-clock cycles of low request per volume step
    localparam logic [1:0] CYC_PER_STEP_M1 = 2'h3;
    // hold-off after each auto-repeat step, in step-clock cycles
    // 40 ms first step is the 4-cycle count itself; following gaps
    // of 400/200/120/80 ms are 4 cycles plus these extras
    localparam logic [5:0] HOLD_1 = 6'h24;
    localparam logic [5:0] HOLD_2 = 6'h10;
    localparam logic [5:0] HOLD_3 = 6'h08;
    localparam logic [5:0] HOLD_4 = 6'h04;
    // volume index width and limits: 0 mute, 1 = -40 dB, 31 = +20 dB
    localparam int unsigned VOL_W = 5;
    localparam logic [4:0] VOL_MUTE = 5'h00;
    localparam logic [4:0] VOL_MIN = 5'h01;
    localparam logic [4:0] VOL_MAX = 5'h1F;
    // gain table entries in dB, bridged-load, and single-ended offset
    localparam logic signed [7:0] GAIN_MUTE_DB = -8'sd85;
    localparam logic signed [7:0] GAIN_MIN_DB = -8'sd40;
    localparam logic signed [7:0] GAIN_STEP_DB = 8'sd2;
    localparam logic signed [7:0] SE_DROP_DB = 8'sd6;
    // step direction
    typedef enum logic [1:0] {UVS_NONE, UVS_UP, UVS_DOWN} uvs_dir_t;
endpackage : uvs_pkg

/* hdl/uvs_sync.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module uvs_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q_sync
);
    logic [W-1:0] meta_r; // first stage, read only by second

    // two flops; no logic between them
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_r <= INIT;
            q_sync <= INIT;
        end else begin
            meta_r <= d_async;
            q_sync <= meta_r;
        end
    end
endmodule : uvs_sync

/* hdl/uvs_stepper.sv */
// up/down volume stepper with internal and external step clock
`timescale 1ns/1ps
module uvs_stepper
    import uvs_pkg::*;
#(
    // internal step-clock divider, shortened in simulation
    parameter int unsigned DIV_CYC = INT_DIV_CYC
) (
    // clock and reset
    sys_clk,
    rst_b,
    // request pins, active low, asynchronous
    vol_up_b,
    vol_down_b,
    // external step clock pin and mode select
    ext_clk,
    ext_clk_sel,
    // output mode select pin
    single_ended_select,
    // volume state
    vol_index,
    gain_db,
    neg_out_hiz,
    step_pulse
);
    input wire logic sys_clk;
    input wire logic rst_b;
    input wire logic vol_up_b;
    input wire logic vol_down_b;
    input wire logic ext_clk;
    input wire logic ext_clk_sel;
    input wire logic single_ended_select;
    output logic [VOL_W-1:0] vol_index;
    output logic signed [7:0] gain_db;
    output logic neg_out_hiz;
    output logic step_pulse;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pins_s; // {sel, se, ext_clk, down_b, up_b}
    uvs_sync #(.W(5), .INIT(5'h03)) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .d_async({ext_clk_sel, single_ended_select, ext_clk, vol_down_b, vol_up_b}),
        .q_sync(pins_s)
    );
    logic up_req; // increase requested
    logic dn_req; // decrease requested
    logic ext_mode; // external clock mode
    logic se_mode; // single-ended mode
    logic ext_clk_s; // synchronised external clock
    assign up_req = !pins_s[0];
    assign dn_req = !pins_s[1];
    assign ext_clk_s = pins_s[2];
    assign se_mode = pins_s[3];
    assign ext_mode = pins_s[4];

    ////////////////////////////////////////////////////////////////////////
    // internal step clock divider
    logic [23:0] div_r; // divider count
    logic int_tick; // one-cycle internal rising edge
    assign int_tick = (div_r == 24'(DIV_CYC - 1));

    // divider runs freely, like the on-chip oscillator
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            div_r <= 24'h000000;
        end else if (int_tick) begin
            div_r <= 24'h000000;
        end else begin
            div_r <= div_r + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external clock rising edge
    logic ext_clk_d_r; // previous synchronised level
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ext_clk_d_r <= 1'b0;
        end else begin
            ext_clk_d_r <= ext_clk_s;
        end
    end

    // selected step clock edge; external replaces internal
    logic tick;
    assign tick = ext_mode ? (ext_clk_s && !ext_clk_d_r) : int_tick;

    ////////////////////////////////////////////////////////////////////////
    // request direction, sampled at each step-clock edge
    uvs_dir_t dir;
    always_comb begin
        // both low at once: treated as no request, avoids fighting steps
        if (up_req && !dn_req) begin
            dir = UVS_UP;
        end else if (dn_req && !up_req) begin
            dir = UVS_DOWN;
        end else begin
            dir = UVS_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle counter and hold-off
    logic [1:0] cyc_r; // low cycles counted toward next step
    logic [5:0] hold_r; // remaining hold-off cycles
    logic [2:0] rep_r; // steps taken in this press
    logic step_go; // step happens on this tick

    // hold-off following the n-th step of a press
    function automatic logic [5:0] hold_after(input logic [2:0] n);
        unique case (n)
            3'h0: hold_after = HOLD_1;
            3'h1: hold_after = HOLD_2;
            3'h2: hold_after = HOLD_3;
            3'h3: hold_after = HOLD_4;
            default: hold_after = 6'h00;
        endcase
    endfunction : hold_after

    assign step_go = tick && (dir != UVS_NONE) && (hold_r == 6'h00)
                     && (cyc_r == CYC_PER_STEP_M1);

    // counts four rising edges with a request low
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cyc_r <= 2'h0;
        end else if (!ext_mode && dir == UVS_NONE) begin
            // internal mode restarts each press
            cyc_r <= 2'h0;
        end else if (tick && dir != UVS_NONE && hold_r == 6'h00) begin
            // wraps after a step; external surplus carries over
            cyc_r <= cyc_r + 2'h1;
        end
    end

    // shrinking hold-off, internal mode only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hold_r <= 6'h00;
            rep_r <= 3'h0;
        end else if (ext_mode || dir == UVS_NONE) begin
            hold_r <= 6'h00;
            rep_r <= 3'h0;
        end else if (step_go) begin
            hold_r <= hold_after(rep_r);
            if (rep_r != 3'h7) begin
                rep_r <= rep_r + 3'h1;
            end
        end else if (tick && hold_r != 6'h00) begin
            hold_r <= hold_r - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // volume index, volatile; reset stands for power-up
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            vol_index <= VOL_MUTE;
        end else if (step_go && dir == UVS_UP) begin
            if (vol_index != VOL_MAX) begin
                vol_index <= vol_index + 5'h01;
            end
        end else if (step_go && dir == UVS_DOWN) begin
            if (vol_index > VOL_MIN) begin
                vol_index <= vol_index - 5'h01;
            end
        end
    end

    // step strobe, launched on the same edge as the index change
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            step_pulse <= 1'b0;
        end else begin
            step_pulse <= step_go;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gain in dB and output stage mode
    logic signed [7:0] btl_db;
    always_comb begin
        if (vol_index == VOL_MUTE) begin
            btl_db = GAIN_MUTE_DB;
        end else begin
            btl_db = GAIN_MIN_DB + GAIN_STEP_DB * $signed({3'h0, vol_index - VOL_MIN});
        end
    end

    // registered gain report and negative-output state
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gain_db <= GAIN_MUTE_DB;
            neg_out_hiz <= 1'b0;
        end else begin
            gain_db <= se_mode ? (btl_db - SE_DROP_DB) : btl_db;
            neg_out_hiz <= se_mode;
        end
    end
endmodule : uvs_stepper

/* verification/uvs_monitor.sv */
// port checker for the volume stepper
`timescale 1ns/1ps
module uvs_monitor
    import uvs_pkg::*;
(
    // clock, reset and pins
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic vol_up_b,
    input wire logic vol_down_b,
    input wire logic single_ended_select,
    // volume state
    input wire logic [VOL_W-1:0] vol_index,
    input wire logic signed [7:0] gain_db,
    input wire logic neg_out_hiz,
    input wire logic step_pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // expected gain of an index, single-ended drop applied
    function automatic logic signed [7:0] f_gain(input logic [4:0] v, input logic se);
        f_gain = (v == VOL_MUTE) ? GAIN_MUTE_DB : GAIN_MIN_DB + GAIN_STEP_DB * ($signed({3'h0, v}) - 8'sh01);
        f_gain = se ? f_gain - SE_DROP_DB : f_gain;
    endfunction : f_gain
    // both requests low long enough to flush syncs and a pending step
    sequence s_both_low; (!vol_up_b && !vol_down_b) [*8]; endsequence
    // select held past the synchroniser
    sequence s_se_high; single_ended_select [*4]; endsequence
    // select held low past the synchroniser
    sequence s_se_low; !single_ended_select [*4]; endsequence
    property p_reset_mute;
        disable iff (1'h0) !rst_b |=> vol_index == VOL_MUTE && gain_db == GAIN_MUTE_DB && !step_pulse;
    endproperty
    property p_one_step;
        $past(rst_b) && vol_index != $past(vol_index) |-> vol_index == $past(vol_index) + 5'h01 || vol_index == $past(vol_index) - 5'h01;
    endproperty
    // mute is left for good; only reset gets back there
    property p_no_mute; $past(rst_b) && $past(vol_index) != VOL_MUTE |-> vol_index != VOL_MUTE; endproperty
    // strobe and index leave the same edge
    property p_pulse; $past(rst_b) && vol_index != $past(vol_index) |-> step_pulse; endproperty
    property p_pulse_one; step_pulse |=> !step_pulse; endproperty
    property p_gain; $past(rst_b) && $stable(vol_index) && $stable(neg_out_hiz) |-> gain_db == f_gain(vol_index, neg_out_hiz); endproperty
    property p_hiz; s_se_high |-> neg_out_hiz; endproperty
    property p_both; s_both_low |-> $stable(vol_index); endproperty
    property p_hiz_off; s_se_low |-> !neg_out_hiz; endproperty
    a_reset_mute: assert property (p_reset_mute) else $error("index not mute after reset");
    a_one_step: assert property (p_one_step) else $error("index moved by more than one");
    a_no_mute: assert property (p_no_mute) else $error("index fell to mute");
    a_pulse: assert property (p_pulse) else $error("no pulse after step");
    a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
    a_gain: assert property (p_gain) else $error("gain does not match index");
    a_hiz: assert property (p_hiz) else $error("negative outputs not released");
    a_both: assert property (p_both) else $error("step with both requests low");
    a_hiz_off: assert property (p_hiz_off) else $error("negative outputs released in bridged mode");
endmodule : uvs_monitor
bind uvs_stepper uvs_monitor mon (.sys_clk, .rst_b, .vol_up_b, .vol_down_b, .single_ended_select, .vol_index, .gain_db, .neg_out_hiz, .step_pulse);

/* verification/uvs_host_model.sv */
// host model: push buttons plus a gated external clock
`timescale 1ns/1ps
module uvs_host_model (
    // pacing clock
    input wire logic sys_clk,
    // request lines, pulled up when released, and gated clock
    output logic up_b,
    output logic down_b,
    output logic ext_clk
);
    // idle: lines released, clock parked low
    initial begin
        up_b = 1'h1;
        down_b = 1'h1;
        ext_clk = 1'h0;
    end
    // wait edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : tick
    // bit 0 up, bit 1 down
    task automatic req(input logic [1:0] d);
        up_b = !d[0];
        down_b = !d[1];
    endtask : req
    // hold request through n slow rises, release after the step lands
    task automatic press(input logic [1:0] d, input int n);
        req(d);
        tick(4);
        repeat (n) begin
            ext_clk = 1'h1;
            tick(5);
            ext_clk = 1'h0;
            tick(5);
        end
        tick(4);
        req(2'h0);
        tick(1);
    endtask : press
endmodule : uvs_host_model

/* verification/test_uvs_stepper.sv */
// self-checking bench for the volume stepper
`timescale 1ns/1ps
module test_uvs_stepper;
    import uvs_pkg::*;
    typedef struct {logic [1:0] d; int n; logic [4:0] v;} uvs_row_t;
    // request, rises, index after; surplus rise carries into the next press
    uvs_row_t rows [8] = '{'{2'h1, 4, 5'h01}, '{2'h1, 4, 5'h02}, '{2'h1, 8, 5'h04}, '{2'h2, 4, 5'h03},
        '{2'h1, 5, 5'h04}, '{2'h1, 3, 5'h05}, '{2'h2, 4, 5'h04}, '{2'h3, 4, 5'h04}};
    int exp_gap [6] = '{0, 400, 200, 120, 80, 40}; // internal step gaps in sys clocks
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic ext_clk_sel = 1'h1;
    logic se_sel = 1'h0;
    wire up_b, dn_b, ext_clk;
    logic [VOL_W-1:0] vol_index;
    logic signed [7:0] gain_db;
    logic neg_out_hiz, step_pulse;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int t0, gap;
    // short internal tick keeps the ramps brief
    uvs_stepper #(.DIV_CYC(10)) dut (.sys_clk, .rst_b, .vol_up_b(up_b), .vol_down_b(dn_b), .ext_clk,
        .ext_clk_sel, .single_ended_select(se_sel), .vol_index, .gain_db, .neg_out_hiz, .step_pulse);
    uvs_host_model host (.sys_clk, .up_b, .down_b(dn_b), .ext_clk);
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // hold a request on the internal tick and time six steps
    task automatic ramp(input logic [1:0] d);
        host.req(d);
        t0 = cyc;
        for (int k = 0; k < 6; k++) begin
            while (step_pulse !== 1'h1) host.tick(1);
            gap = cyc - t0;
            t0 = cyc;
            if (k == 0) check("first", 8'(gap >= 30 && gap <= 52), 8'h01);
            else check("gap", 8'(gap), 8'(exp_gap[k]));
            host.tick(1);
        end
        host.req(2'h0);
        host.tick(4);
    endtask : ramp
    initial begin
        host.tick(12);
        check("vol", 8'(vol_index), 8'h00);
        check("gain", gain_db, 8'hAB);
        rst_b = 1'h1;
        host.tick(2);
        foreach (rows[i]) begin
            host.press(rows[i].d, rows[i].n);
            check("vol", 8'(vol_index), 8'(rows[i].v));
        end
        se_sel = 1'h1;
        host.tick(6);
        check("hiz", 8'(neg_out_hiz), 8'h01);
        check("gain", gain_db, 8'hD8);
        se_sel = 1'h0;
        host.press(2'h1, 120);
        check("vol", 8'(vol_index), 8'h1F);
        check("gain", gain_db, 8'h14);
        ext_clk_sel = 1'h0;
        host.tick(4);
        ramp(2'h2);
        check("vol", 8'(vol_index), 8'h19);
        ramp(2'h1);
        check("vol", 8'(vol_index), 8'h1F);
        ext_clk_sel = 1'h1;
        host.tick(4);
        host.press(2'h2, 128);
        check("vol", 8'(vol_index), 8'h01);
        rst_b = 1'h0;
        host.tick(3);
        check("vol", 8'(vol_index), 8'h00);
        rst_b = 1'h1;
        host.tick(3);
        check("gain", gain_db, 8'hAB);
        stop_test();
    end
endmodule : test_uvs_stepper
